//--- design/dtc_pin_sync.sv
`default_nettype none
module dtc_pin_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output logic      level,
	output logic      fall
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} dtc_sync_t;

	dtc_sync_t q;
	dtc_sync_t d;

	// A change counts only once the second and third stages agree
	always_comb begin
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 == q.s3) begin
			d.lvl = q.s2;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.lvl;
	// RQ21 high then low
	assign fall = q.lvl & (q.s2 == q.s3) & ~q.s2;
endmodule // dtc_pin_sync
`default_nettype wire

//--- design/dtc_pkg.sv
`default_nettype none
package dtc_pkg;
	localparam int IDX_W = 10;
	localparam int DATA_W = 8;
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_RUN_FLAGS = 10'h088;
	localparam logic [IDX_W-1:0] IDX_MODE_SETUP = 10'h089;
	localparam logic [IDX_W-1:0] IDX_LOW_A = 10'h08a;
	localparam logic [IDX_W-1:0] IDX_LOW_B = 10'h08b;
	localparam logic [IDX_W-1:0] IDX_HIGH_A = 10'h08c;
	localparam logic [IDX_W-1:0] IDX_HIGH_B = 10'h08d;
	localparam logic [IDX_W-1:0] IDX_PRESCALE = 10'h08e;
	localparam logic [IDX_W-1:0] IDX_IRQ_EN = 10'h0a8;
	localparam logic [IDX_W-1:0] IDX_IRQ_PRIO = 10'h0b8;
	localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
	// timer_run_and_flags fields
	localparam int RUN_A_BIT = 4;
	localparam int FLAG_A_BIT = 5;
	localparam int RUN_B_BIT = 6;
	localparam int FLAG_B_BIT = 7;
	// timer_mode_setup: one nibble per timer
	localparam int NIB_W = 4;
	localparam int MODE_OFS = 0;
	localparam int MODE_W = 2;
	localparam int SRC_OFS = 2;
	localparam int GATE_OFS = 3;
	// prescale_choice, interrupt_enable_bits, interrupt_priority_bits
	localparam int PRE_A_BIT = 3;
	localparam int PRE_B_BIT = 4;
	localparam int GLOBAL_IRQ_BIT = 7;
	localparam int IRQ_A_BIT = 1;
	localparam int IRQ_B_BIT = 3;
	localparam int PRIO_A_BIT = 1;
	localparam int PRIO_B_BIT = 3;
	// Prescaler
	localparam int PRE_W = 4;
	localparam logic [PRE_W-1:0] DIV_FAST = 4'h4;
	localparam logic [PRE_W-1:0] DIV_SLOW = 4'hc;
	// Count widths
	localparam int LOW13_W = 5;
	localparam int CNT13_W = 13;
	// Interrupt vectors and natural priority (lower is served first)
	localparam logic [DATA_W-1:0] VEC_A = 8'h0b;
	localparam logic [DATA_W-1:0] VEC_B = 8'h1b;
	localparam logic [DATA_W-1:0] VEC_NONE = 8'h00;
	localparam int NAT_PRIO_A = 2;
	localparam int NAT_PRIO_B = 4;
	// Pin index in the synchroniser bank
	localparam int PIN_GATE_OFS = 2;

	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_RELOAD8,
		MODE_SPLIT
	} dtc_mode_t;

	typedef enum logic [3:0] {
		SEL_NONE,
		SEL_RUN_FLAGS,
		SEL_MODE_SETUP,
		SEL_LOW_A,
		SEL_LOW_B,
		SEL_HIGH_A,
		SEL_HIGH_B,
		SEL_PRESCALE,
		SEL_IRQ_EN,
		SEL_IRQ_PRIO
	} dtc_sel_t;

	function automatic dtc_sel_t dtc_decode(input logic [IDX_W-1:0] idx);
		case (idx)
			IDX_RUN_FLAGS: dtc_decode = SEL_RUN_FLAGS;
			IDX_MODE_SETUP: dtc_decode = SEL_MODE_SETUP;
			IDX_LOW_A: dtc_decode = SEL_LOW_A;
			IDX_LOW_B: dtc_decode = SEL_LOW_B;
			IDX_HIGH_A: dtc_decode = SEL_HIGH_A;
			IDX_HIGH_B: dtc_decode = SEL_HIGH_B;
			IDX_PRESCALE: dtc_decode = SEL_PRESCALE;
			IDX_IRQ_EN: dtc_decode = SEL_IRQ_EN;
			IDX_IRQ_PRIO: dtc_decode = SEL_IRQ_PRIO;
			default: dtc_decode = SEL_NONE;
		endcase
	endfunction
endpackage
`default_nettype wire

//--- design/dtc_timer.sv
// How it works
// RQ1: Counter mode advances on falling count pin; gate pin is active high.
// RQ2: Mode 0 counts 13 bits: high byte over low five bits.
// RQ3: Modes 0 and 1 set the overflow flag on all-ones rollover.
// RQ4: Mode 1 cascades high and low bytes into one 16-bit counter.
// RQ5: Mode 2 counts low byte, reloads it from high byte on overflow.
// RQ6: Timer a mode 3 splits; high half runs on run_bit_b, sets flag b.
// RQ7: Timer b in mode 3 holds its count, as if stopped.
// RQ8: With timer a split, timer b still counts; flag b from split half.
// RQ9: Gate enable set needs gate pin high plus run bit to count.
// RQ10: Source select picks count pin pulses or prescaled clock.
// RQ11: Mode register: timer a low nibble, timer b high nibble.
// RQ12: Run and flag bits at 4,5 (timer a) and 6,7 (timer b).
// RQ13: Prescale bit selects clock divide by 4, else by 12.
// RQ14: Overflow flag clears when the core enters that timer's handler.
// RQ15: Vectors 0x0b and 0x1b, natural priorities 2 and 4.
// RQ16: Software set or clear of a flag acts like hardware.
// RQ17: Interrupt requests need global enable and the timer's enable.
// RQ18: Priority bit at one puts the timer in the high group.
// RQ19: Timer mode counts once per 4 or 12 clock periods.
// RQ20: Count pins are sampled every clock for edge detection.
// RQ21: Falling edge is a high sample then low; counts only when enabled.
`default_nettype none
module dtc_timer #(
	parameter int APB_AW = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              count_pin_a,
	input  wire logic              count_pin_b,
	input  wire logic              gate_pin_a,
	input  wire logic              gate_pin_b,
	input  wire logic              irq_ack_a,
	input  wire logic              irq_ack_b,
	output logic                   irq_req_a,
	output logic                   irq_req_b,
	output logic                   irq_high_a,
	output logic                   irq_high_b,
	output logic [7:0]             irq_vector
);
	typedef struct packed {
		logic [7:0]                     mode_setup;
		logic [1:0]                     run;
		logic [1:0]                     flag;
		logic [1:0]                     pre_sel;
		logic                           global_on;
		logic [1:0]                     irq_on;
		logic [1:0]                     prio;
		logic [1:0][7:0]                hi;
		logic [1:0][7:0]                lo;
		logic [1:0][dtc_pkg::PRE_W-1:0] pre;
		logic [7:0]                     rdata;
		logic [7:0]                     vector;
	} dtc_state_t;

	localparam int FIRST = (dtc_pkg::NAT_PRIO_A < dtc_pkg::NAT_PRIO_B) ? 0 : 1;

	dtc_state_t        q;
	dtc_state_t        d;
	dtc_pkg::dtc_sel_t sel;
	dtc_pkg::dtc_mode_t mode [2];
	logic              wr;
	logic [1:0]        tick;
	logic [1:0]        run;
	logic [1:0]        inc;
	logic [1:0]        hw_set;
	logic [1:0]        req;
	logic [1:0]        ack;
	logic              split_inc;
	logic [16:0]       step_r;
	logic [3:0]        pin_raw;
	logic [3:0]        pin_lvl;
	logic [3:0]        pin_fall;
	logic [7:0]        rd;

	// One counting step: {overflow, high, low}
	function automatic logic [16:0] dtc_step(input dtc_pkg::dtc_mode_t m,
			input logic [7:0] h, input logic [7:0] l);
		logic [dtc_pkg::CNT13_W:0] c13;
		logic [16:0]               c16;
		logic [8:0]                c8;
		c13 = {1'b0, h, l[dtc_pkg::LOW13_W-1:0]} + 14'h0001;
		c16 = {1'b0, h, l} + 17'h00001;
		c8 = {1'b0, l} + 9'h001;
		unique case (m)
			// RQ2 thirteen bit
			dtc_pkg::MODE_13BIT: dtc_step = {c13[dtc_pkg::CNT13_W],
				c13[dtc_pkg::CNT13_W-1:dtc_pkg::LOW13_W],
				l[7:dtc_pkg::LOW13_W], c13[dtc_pkg::LOW13_W-1:0]};
			// RQ4 cascaded sixteen bit
			dtc_pkg::MODE_16BIT: dtc_step = c16;
			// RQ5 reload from high
			dtc_pkg::MODE_RELOAD8: dtc_step = {c8[8], h, c8[8] ? h : c8[7:0]};
			dtc_pkg::MODE_SPLIT: dtc_step = {c8[8], h, c8[7:0]};
		endcase
	endfunction

	// RQ1 falling count, gate high
	assign pin_raw = {gate_pin_b, gate_pin_a, count_pin_b, count_pin_a};
	assign ack = {irq_ack_b, irq_ack_a};

	// RQ20 sample every clock
	for (genvar g = 0; g < 4; g++) begin : g_pin
		dtc_pin_sync u_sync (
			.pclk    (pclk),
			.presetn (presetn),
			.pin     (pin_raw[g]),
			.level   (pin_lvl[g]),
			.fall    (pin_fall[g])
		);
	end

	always_comb begin
		d = q;
		step_r = '0;
		hw_set = '0;
		wr = psel & penable & pwrite & pstrb[0];
		sel = dtc_pkg::dtc_decode(paddr[APB_AW-1:2]);
		for (int i = 0; i < 2; i++) begin
			// RQ13 divide by 4 or 12
			tick[i] = q.pre[i] == ((q.pre_sel[i] ? dtc_pkg::DIV_FAST
				: dtc_pkg::DIV_SLOW) - 4'h1);
			d.pre[i] = tick[i] ? '0 : q.pre[i] + 4'h1;
			mode[i] = dtc_pkg::dtc_mode_t'(q.mode_setup[i * dtc_pkg::NIB_W
				+ dtc_pkg::MODE_OFS +: dtc_pkg::MODE_W]);
			// RQ9 gate and run
			run[i] = q.run[i] & (~q.mode_setup[i * dtc_pkg::NIB_W
				+ dtc_pkg::GATE_OFS] | pin_lvl[dtc_pkg::PIN_GATE_OFS + i]);
		end
		// RQ7 mode 3 stops timer b
		if (mode[1] == dtc_pkg::MODE_SPLIT) begin
			run[1] = 1'b0;
		end
		for (int i = 0; i < 2; i++) begin
			// RQ10 pin or prescaled clock
			inc[i] = run[i] & (q.mode_setup[i * dtc_pkg::NIB_W
				+ dtc_pkg::SRC_OFS] ? pin_fall[i] : tick[i]);
		end
		// RQ19 increment on enabled tick
		if (inc[0]) begin
			step_r = dtc_step(mode[0], q.hi[0], q.lo[0]);
			{d.hi[0], d.lo[0]} = step_r[15:0];
			// RQ3 rollover flag
			hw_set[0] = step_r[16];
		end
		if (inc[1]) begin
			{hw_set[1], d.hi[1], d.lo[1]} =
				dtc_step(mode[1], q.hi[1], q.lo[1]);
		end
		// RQ6 split high half
		split_inc = (mode[0] == dtc_pkg::MODE_SPLIT) & q.run[1] & tick[0];
		// RQ8 flag b owned by split half
		if (mode[0] == dtc_pkg::MODE_SPLIT) begin
			hw_set[1] = split_inc & (&q.hi[0]);
		end
		if (split_inc) begin
			d.hi[0] = q.hi[0] + 8'h01;
		end
		// RQ14 core entry clears
		d.flag = q.flag & ~ack;
		// Software writes to the count bytes win over counting in the same cycle
		if (wr) begin
			unique case (sel)
				dtc_pkg::SEL_RUN_FLAGS: begin
					// RQ12 run and flag bits
					d.run[0] = pwdata[dtc_pkg::RUN_A_BIT];
					d.run[1] = pwdata[dtc_pkg::RUN_B_BIT];
					// RQ16 software flag access
					d.flag[0] = pwdata[dtc_pkg::FLAG_A_BIT];
					d.flag[1] = pwdata[dtc_pkg::FLAG_B_BIT];
				end
				// RQ11 mode nibbles
				dtc_pkg::SEL_MODE_SETUP: d.mode_setup = pwdata[7:0];
				dtc_pkg::SEL_LOW_A: d.lo[0] = pwdata[7:0];
				dtc_pkg::SEL_LOW_B: d.lo[1] = pwdata[7:0];
				dtc_pkg::SEL_HIGH_A: d.hi[0] = pwdata[7:0];
				dtc_pkg::SEL_HIGH_B: d.hi[1] = pwdata[7:0];
				dtc_pkg::SEL_PRESCALE: begin
					d.pre_sel[0] = pwdata[dtc_pkg::PRE_A_BIT];
					d.pre_sel[1] = pwdata[dtc_pkg::PRE_B_BIT];
				end
				dtc_pkg::SEL_IRQ_EN: begin
					d.global_on = pwdata[dtc_pkg::GLOBAL_IRQ_BIT];
					d.irq_on[0] = pwdata[dtc_pkg::IRQ_A_BIT];
					d.irq_on[1] = pwdata[dtc_pkg::IRQ_B_BIT];
				end
				dtc_pkg::SEL_IRQ_PRIO: begin
					d.prio[0] = pwdata[dtc_pkg::PRIO_A_BIT];
					d.prio[1] = pwdata[dtc_pkg::PRIO_B_BIT];
				end
				dtc_pkg::SEL_NONE: begin
				end
			endcase
		end
		// Hardware set wins over any clear in the same cycle
		d.flag = d.flag | hw_set;
		// Read data is latched in the setup phase, so no wait state
		rd = dtc_pkg::RESET_BYTE;
		unique case (sel)
			dtc_pkg::SEL_RUN_FLAGS: begin
				rd[dtc_pkg::RUN_A_BIT] = q.run[0];
				rd[dtc_pkg::FLAG_A_BIT] = q.flag[0];
				rd[dtc_pkg::RUN_B_BIT] = q.run[1];
				rd[dtc_pkg::FLAG_B_BIT] = q.flag[1];
			end
			dtc_pkg::SEL_MODE_SETUP: rd = q.mode_setup;
			dtc_pkg::SEL_LOW_A: rd = q.lo[0];
			dtc_pkg::SEL_LOW_B: rd = q.lo[1];
			dtc_pkg::SEL_HIGH_A: rd = q.hi[0];
			dtc_pkg::SEL_HIGH_B: rd = q.hi[1];
			dtc_pkg::SEL_PRESCALE: begin
				rd[dtc_pkg::PRE_A_BIT] = q.pre_sel[0];
				rd[dtc_pkg::PRE_B_BIT] = q.pre_sel[1];
			end
			dtc_pkg::SEL_IRQ_EN: begin
				rd[dtc_pkg::GLOBAL_IRQ_BIT] = q.global_on;
				rd[dtc_pkg::IRQ_A_BIT] = q.irq_on[0];
				rd[dtc_pkg::IRQ_B_BIT] = q.irq_on[1];
			end
			dtc_pkg::SEL_IRQ_PRIO: begin
				rd[dtc_pkg::PRIO_A_BIT] = q.prio[0];
				rd[dtc_pkg::PRIO_B_BIT] = q.prio[1];
			end
			dtc_pkg::SEL_NONE: begin
			end
		endcase
		if (psel & ~penable) begin
			d.rdata = rd;
		end
		// RQ17 global and own enable
		req = q.flag & q.irq_on & {2{q.global_on}};
		// RQ18 high group first
		if (req[FIRST] & q.prio[FIRST]) begin
			d.vector = FIRST == 0 ? dtc_pkg::VEC_A : dtc_pkg::VEC_B;
		end else if (req[1 - FIRST] & q.prio[1 - FIRST]) begin
			d.vector = FIRST == 0 ? dtc_pkg::VEC_B : dtc_pkg::VEC_A;
		// RQ15 natural order then
		end else if (req[FIRST]) begin
			d.vector = FIRST == 0 ? dtc_pkg::VEC_A : dtc_pkg::VEC_B;
		end else if (req[1 - FIRST]) begin
			d.vector = FIRST == 0 ? dtc_pkg::VEC_B : dtc_pkg::VEC_A;
		end else begin
			d.vector = dtc_pkg::VEC_NONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign prdata = {24'h000000, q.rdata};
	assign pready = 1'b1;
	assign pslverr = psel & penable & (sel == dtc_pkg::SEL_NONE);
	assign irq_req_a = req[0];
	assign irq_req_b = req[1];
	assign irq_high_a = q.prio[0];
	assign irq_high_b = q.prio[1];
	assign irq_vector = q.vector;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_reload8;
		mode[0] == dtc_pkg::MODE_RELOAD8 && inc[0] && (&q.lo[0]) && !wr
			|=> q.lo[0] == $past(q.hi[0]) && q.flag[0]
				&& $stable(q.hi[0]);
	endproperty
	a_reload8: assert property (p_reload8) // RQ5
		else $error("mode 2 reload or flag missing");

	property p_roll16;
		mode[0] == dtc_pkg::MODE_16BIT && inc[0] && (&{q.hi[0], q.lo[0]})
			&& !wr |=> {q.hi[0], q.lo[0]} == '0 && q.flag[0];
	endproperty
	a_roll16: assert property (p_roll16) // RQ3
		else $error("16-bit rollover wrong");

	property p_hold_b;
		mode[1] == dtc_pkg::MODE_SPLIT && mode[0] != dtc_pkg::MODE_SPLIT
			&& !wr |=> $stable(q.lo[1]) && $stable(q.hi[1]);
	endproperty
	a_hold_b: assert property (p_hold_b) // RQ7
		else $error("timer b moved in mode 3");

	property p_gate_a;
		!run[0] && !wr |=> $stable(q.lo[0]);
	endproperty
	a_gate_a: assert property (p_gate_a) // RQ9
		else $error("timer a low byte moved while disabled");

	property p_fast;
		tick[0] && q.pre_sel[0] |=> !tick[0] [*3];
	endproperty
	a_fast: assert property (p_fast) // RQ13
		else $error("prescale tick too soon");

	property p_ack_a;
		irq_ack_a && !hw_set[0] && !wr |=> !q.flag[0] && !irq_req_a;
	endproperty
	a_ack_a: assert property (p_ack_a) // RQ14
		else $error("flag a not cleared on core entry");

	property p_irq_gate;
		wr && sel == dtc_pkg::SEL_IRQ_EN && !pwdata[dtc_pkg::GLOBAL_IRQ_BIT]
			|=> !irq_req_a && !irq_req_b;
	endproperty
	a_irq_gate: assert property (p_irq_gate) // RQ17
		else $error("request without global enable");

	property p_split_hi;
		mode[0] == dtc_pkg::MODE_SPLIT && q.run[1] && tick[0]
			&& (&q.hi[0]) && !wr |=> q.flag[1] && q.hi[0] == '0;
	endproperty
	a_split_hi: assert property (p_split_hi) // RQ6
		else $error("split high half overflow wrong");

	property p_count_pin;
		mode[0] == dtc_pkg::MODE_16BIT && run[0] && pin_fall[0]
			&& q.mode_setup[dtc_pkg::SRC_OFS] && !(&q.lo[0]) && !wr
			|=> q.lo[0] == $past(q.lo[0]) + 8'h01;
	endproperty
	a_count_pin: assert property (p_count_pin) // RQ1
		else $error("falling edge not counted");

	property p_sw_set;
		wr && sel == dtc_pkg::SEL_RUN_FLAGS
			&& pwdata[dtc_pkg::FLAG_A_BIT] && q.global_on && q.irq_on[0]
			&& !irq_ack_a |=> irq_req_a;
	endproperty
	a_sw_set: assert property (p_sw_set) // RQ16
		else $error("software set gave no request");

	property p_vector;
		irq_req_a && q.prio[0] |=> irq_vector == dtc_pkg::VEC_A;
	endproperty
	a_vector: assert property (p_vector) // RQ18
		else $error("high group timer a not served");

	c_reload: cover property (mode[0] == dtc_pkg::MODE_RELOAD8 && inc[0]
		&& (&q.lo[0]));
	c_split: cover property (split_inc && (&q.hi[0]));
	c_pin: cover property (inc[1] && pin_fall[1]);
	c_vec_b: cover property (irq_vector == dtc_pkg::VEC_B);
endmodule // dtc_timer
`default_nettype wire

//--- dv/dtc_pin_model.sv
`default_nettype none
module dtc_pin_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       go,
	input  wire logic [7:0] pulses,
	input  wire logic       gate_level,
	output logic            busy,
	output logic            count_pin,
	output logic            gate_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] left_q;
	logic [2:0] ph_q;
	// Low and high four clocks each, so no pulse is lost in the sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q <= 8'h00;
			ph_q <= 3'h0;
		end else if (go) begin
			left_q <= pulses;
			ph_q <= 3'h0;
		end else if (left_q != 8'h00) begin
			ph_q <= ph_q + 3'h1;
			if (ph_q == 3'h7) begin
				left_q <= left_q - 8'h01;
			end
		end
	end
	assign busy = (left_q != 8'h00);
	// Idle high: only a burst makes falling edges
	assign count_pin = !(busy && !ph_q[2]);
	assign gate_pin = gate_level;
endmodule // dtc_pin_model
`default_nettype wire

//--- dv/tb_dtc_timer.sv
`default_nettype none
module tb_dtc_timer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic        pin_a, pin_b, gt_a, gt_b, ack_a, ack_b;
	logic        req_a, req_b, high_a, high_b, e;
	logic        go_a, go_b, gl_a, gl_b, busy_a, busy_b;
	logic [7:0]  vec, np, v;
	int          num_errors, samples_checked, cycles;
	logic [9:0]  idxs [9] = '{dtc_pkg::IDX_RUN_FLAGS,
		dtc_pkg::IDX_MODE_SETUP, dtc_pkg::IDX_LOW_A, dtc_pkg::IDX_LOW_B,
		dtc_pkg::IDX_HIGH_A, dtc_pkg::IDX_HIGH_B, dtc_pkg::IDX_PRESCALE,
		dtc_pkg::IDX_IRQ_EN, dtc_pkg::IDX_IRQ_PRIO};

	dtc_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.count_pin_a(pin_a), .count_pin_b(pin_b), .gate_pin_a(gt_a),
		.gate_pin_b(gt_b), .irq_ack_a(ack_a), .irq_ack_b(ack_b),
		.irq_req_a(req_a), .irq_req_b(req_b), .irq_high_a(high_a),
		.irq_high_b(high_b), .irq_vector(vec));
	dtc_pin_model pa (.pclk(pclk), .presetn(presetn), .go(go_a),
		.pulses(np), .gate_level(gl_a), .busy(busy_a), .count_pin(pin_a),
		.gate_pin(gt_a));
	dtc_pin_model pb (.pclk(pclk), .presetn(presetn), .go(go_b),
		.pulses(np), .gate_level(gl_b), .busy(busy_b), .count_pin(pin_b),
		.gate_pin(gt_b));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Cut a hang short well above the expected run length
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [9:0] idx,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		v = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rd(input logic [9:0] idx, input string what,
		input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(what, exp, v);
	endtask

	task automatic pulse(input logic b, input logic [7:0] n);
		@(posedge pclk);
		np <= n;
		go_a <= !b;
		go_b <= b;
		@(posedge pclk);
		go_a <= 1'b0;
		go_b <= 1'b0;
		@(posedge pclk);
		while (busy_a || busy_b) @(posedge pclk);
		repeat (6) @(posedge pclk);
	endtask

	task automatic run_for(input logic [7:0] pre);
		wr(dtc_pkg::IDX_LOW_A, 8'h00);
		wr(dtc_pkg::IDX_PRESCALE, pre);
		wr(dtc_pkg::IDX_RUN_FLAGS, 8'h10);
		repeat (48) @(posedge pclk);
		wr(dtc_pkg::IDX_RUN_FLAGS, 8'h00);
		apb(1'b0, dtc_pkg::IDX_LOW_A, 8'h00);
	endtask

	initial begin
		{presetn, psel, penable, pwrite, ack_a, ack_b} = '0;
		{go_a, go_b, gl_a, gl_b} = '0;
		{paddr, pwdata, np} = '0;
		pstrb = 4'hf;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (idxs[i]) rd(idxs[i], "reset", 8'h00);
		apb(1'b0, 10'h3ff, 8'h00);
		chk("unmapped err", 8'h01, {7'h00, e});
		wr(dtc_pkg::IDX_MODE_SETUP, 8'ha5);
		rd(dtc_pkg::IDX_MODE_SETUP, "mode rw", 8'ha5);
		wr(dtc_pkg::IDX_MODE_SETUP, 8'h01);
		run_for(8'h08);
		chk("div4", 8'h01, {7'h00, v inside {[11:14]}});
		run_for(8'h00);
		chk("div12", 8'h01, {7'h00, v inside {[3:5]}});
		// Counter mode 1 rolls over from all ones
		wr(dtc_pkg::IDX_MODE_SETUP, 8'h05);
		wr(dtc_pkg::IDX_LOW_A, 8'hff);
		wr(dtc_pkg::IDX_HIGH_A, 8'hff);
		wr(dtc_pkg::IDX_RUN_FLAGS, 8'h10);
		pulse(1'b0, 8'h01);
		rd(dtc_pkg::IDX_LOW_A, "m1 low", 8'h00);
		rd(dtc_pkg::IDX_HIGH_A, "m1 high", 8'h00);
		rd(dtc_pkg::IDX_RUN_FLAGS, "m1 flag", 8'h30);
		wr(dtc_pkg::IDX_IRQ_EN, 8'h02);
		repeat (3) @(posedge pclk);
		chk("req no global", 8'h00, {7'h00, req_a});
		wr(dtc_pkg::IDX_IRQ_EN, 8'h82);
		wr(dtc_pkg::IDX_IRQ_PRIO, 8'h02);
		repeat (3) @(posedge pclk);
		chk("req a", 8'h01, {7'h00, req_a});
		chk("vec a", 8'h0b, vec);
		chk("high a", 8'h01, {7'h00, high_a});
		ack_a <= 1'b1;
		@(posedge pclk);
		ack_a <= 1'b0;
		rd(dtc_pkg::IDX_RUN_FLAGS, "ack clear", 8'h10);
		// 13-bit: carry out of low five bits reaches the high byte
		wr(dtc_pkg::IDX_MODE_SETUP, 8'h04);
		wr(dtc_pkg::IDX_LOW_A, 8'h1f);
		pulse(1'b0, 8'h01);
		apb(1'b0, dtc_pkg::IDX_LOW_A, 8'h00);
		chk("m0 low", 8'h00, v & 8'h1f);
		rd(dtc_pkg::IDX_HIGH_A, "m0 high", 8'h01);
		wr(dtc_pkg::IDX_HIGH_A, 8'hff);
		wr(dtc_pkg::IDX_LOW_A, 8'h1f);
		pulse(1'b0, 8'h01);
		rd(dtc_pkg::IDX_RUN_FLAGS, "m0 flag", 8'h30);
		// Software flag writes act like the hardware event
		wr(dtc_pkg::IDX_RUN_FLAGS, 8'h00);
		repeat (3) @(posedge pclk);
		chk("sw clear", 8'h00, {7'h00, req_a});
		wr(dtc_pkg::IDX_RUN_FLAGS, 8'h20);
		repeat (3) @(posedge pclk);
		chk("sw set", 8'h01, {7'h00, req_a});
		wr(dtc_pkg::IDX_RUN_FLAGS, 8'h10);
		// Gate low blocks the count pin
		wr(dtc_pkg::IDX_MODE_SETUP, 8'h0d);
		wr(dtc_pkg::IDX_LOW_A, 8'h00);
		pulse(1'b0, 8'h02);
		rd(dtc_pkg::IDX_LOW_A, "gate low", 8'h00);
		gl_a <= 1'b1;
		pulse(1'b0, 8'h03);
		rd(dtc_pkg::IDX_LOW_A, "gate high", 8'h03);
		// Timer a counter mode 2 reloads from its high byte
		wr(dtc_pkg::IDX_MODE_SETUP, 8'h06);
		wr(dtc_pkg::IDX_HIGH_A, 8'hfe);
		wr(dtc_pkg::IDX_LOW_A, 8'hff);
		pulse(1'b0, 8'h01);
		rd(dtc_pkg::IDX_LOW_A, "a reload", 8'hfe);
		rd(dtc_pkg::IDX_RUN_FLAGS, "a m2 flag", 8'h30);
		// Timer b counter mode 2 reloads from the high byte
		wr(dtc_pkg::IDX_MODE_SETUP, 8'h60);
		wr(dtc_pkg::IDX_HIGH_B, 8'hfd);
		wr(dtc_pkg::IDX_LOW_B, 8'hfd);
		wr(dtc_pkg::IDX_RUN_FLAGS, 8'h40);
		pulse(1'b1, 8'h03);
		rd(dtc_pkg::IDX_LOW_B, "reload", 8'hfd);
		rd(dtc_pkg::IDX_HIGH_B, "high kept", 8'hfd);
		rd(dtc_pkg::IDX_RUN_FLAGS, "m2 flag", 8'hc0);
		wr(dtc_pkg::IDX_IRQ_EN, 8'h88);
		wr(dtc_pkg::IDX_IRQ_PRIO, 8'h08);
		repeat (3) @(posedge pclk);
		chk("vec b", 8'h1b, vec);
		chk("high b", 8'h01, {7'h00, high_b});
		chk("req b", 8'h01, {7'h00, req_b});
		ack_b <= 1'b1;
		@(posedge pclk);
		ack_b <= 1'b0;
		rd(dtc_pkg::IDX_RUN_FLAGS, "ack b clear", 8'h40);
		// Split: high half of a runs on run bit b and sets flag b
		wr(dtc_pkg::IDX_MODE_SETUP, 8'h13);
		wr(dtc_pkg::IDX_PRESCALE, 8'h18);
		wr(dtc_pkg::IDX_RUN_FLAGS, 8'h40);
		wr(dtc_pkg::IDX_HIGH_A, 8'hff);
		wr(dtc_pkg::IDX_LOW_A, 8'h00);
		wr(dtc_pkg::IDX_LOW_B, 8'h00);
		repeat (20) @(posedge pclk);
		rd(dtc_pkg::IDX_RUN_FLAGS, "split flag", 8'hc0);
		rd(dtc_pkg::IDX_LOW_A, "split low", 8'h00);
		apb(1'b0, dtc_pkg::IDX_LOW_B, 8'h00);
		chk("b runs", 8'h01, {7'h00, v != 8'h00});
		wr(dtc_pkg::IDX_MODE_SETUP, 8'h33);
		wr(dtc_pkg::IDX_LOW_B, 8'h55);
		repeat (20) @(posedge pclk);
		rd(dtc_pkg::IDX_LOW_B, "b held", 8'h55);
		print_verdict();
	end
endmodule // tb_dtc_timer
`default_nettype wire
